// File: include/cbdiag_map.svh
/*
  register offsets, field positions and reset values of the bus
  diagnostics and upper filter routing block.
  assumes a 16-bit register port with word indexes.
*/
`ifndef CBDIAG_MAP_SVH
`define CBDIAG_MAP_SVH

// ----------------------------------------------------------------
// register indexes
// ----------------------------------------------------------------
`define CBDIAG_DATA_CNT_ADDR    4'h0
`define CBDIAG_NOM_CNT_ADDR     4'h1
`define CBDIAG_FLAGS_ADDR       4'h2
`define CBDIAG_EFMSG_ADDR       4'h3
`define CBDIAG_FLT_BASE_ADDR    4'h4
`define CBDIAG_FLT_LAST_ADDR    4'h7

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define CBDIAG_TX_CNT_MSB       15
`define CBDIAG_TX_CNT_LSB       8
`define CBDIAG_RX_CNT_MSB       7
`define CBDIAG_RX_CNT_LSB       0
`define CBDIAG_FLAG_MASK        16'hFBBF
`define CBDIAG_FLT_MASK         16'h9F9F
`define CBDIAG_FLT_EN_BIT       7
`define CBDIAG_FLT_PTR_MSB      4
`define CBDIAG_PTR_MIN          5'h01
`define CBDIAG_PTR_MAX          5'h07
`define CBDIAG_RECESSIVE_RUN    4'hB

// flag bit positions
`define CBDIAG_F_LENGTH_MISMATCH_FLAG          15
`define CBDIAG_F_ESI            14
`define CBDIAG_F_DCRC           13
`define CBDIAG_F_DSTUF          12
`define CBDIAG_F_DFORM          11
`define CBDIAG_F_DBIT1          9
`define CBDIAG_F_DBIT0          8
`define CBDIAG_F_BOFF           7
`define CBDIAG_F_NCRC           5
`define CBDIAG_F_NSTUF          4
`define CBDIAG_F_NFORM          3
`define CBDIAG_F_NACK           2
`define CBDIAG_F_NBIT1          1
`define CBDIAG_F_NBIT0          0

`define CBDIAG_RESET_VAL        16'h0000

`endif

// File: include/cbdiag_pkg.sv
/*
  types of the bus diagnostics block.
  assumes nothing beyond the map header.
*/
`default_nettype none
package cbdiag_pkg;
  typedef logic [15:0] cbdiag_word_t;
  typedef logic [4:0]  cbdiag_ptr_t;
  typedef enum logic [1:0] {
    CBDIAG_RUN  = 2'h1,
    CBDIAG_BOFF = 2'h2
  } cbdiag_state_t;
endpackage
`default_nettype wire

// File: logic/cbdiag_core.sv
/*
  bus diagnostics counters, sticky error flags, error-free message
  counter and the upper filter routing words.
  assumes the protocol engine gives one-cycle event pulses on clk,
  already synchronous; bus sample is a pin and is synchronised here.
*/
`include "cbdiag_map.svh"
`default_nettype none

// Notes on behaviour
// - data phase tx/rx counters, register 0, tx high
// - nominal phase tx/rx counters, register 1, tx high
// - flag length code exceeding fifo payload size
// - flag received frame with esi set
// - data phase crc stuff form bit flags
// - flag bus-off entry followed by auto-recovery
// - flag received crc mismatch
// - flag more than five equal bits
// - flag illegal fixed-format field
// - flag transmitted frame not acknowledged
// - flag recessive sent, dominant seen
// - flag dominant sent, recessive seen
// - recovery: flag every eleven recessive bits
// - 16-bit error-free message counter, read/write
// - bits 10 and 6 read zero
// - upper filter word: filters c low, d high
// - disabled filter takes no part
// - hit stores to object given by pointer
module cbdiag_core
  import cbdiag_pkg::*;
#(
  parameter int NUM_FLT_WORDS = 4
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        data_phase,
  input  wire logic        tx_err_inc,
  input  wire logic        rx_err_inc,
  input  wire logic        dlc_check,
  input  wire logic [3:0]  frame_dlc,
  input  wire logic [2:0]  fifo_payload_size,
  input  wire logic        rx_esi_seen,
  input  wire logic        crc_err,
  input  wire logic        stuff_err,
  input  wire logic        form_err,
  input  wire logic        ack_err,
  input  wire logic        bit1_err,
  input  wire logic        bit0_err,
  input  wire logic        bus_off_enter,
  input  wire logic        bus_off_exit,
  input  wire logic        bit_tick,
  input  wire logic        bus_rx_pin,
  input  wire logic        frame_ok,
  input  wire logic        flt_hit,
  input  wire logic [3:0]  flt_hit_index,
  output logic             store_valid,
  output logic      [4:0]  store_object,
  output logic             flt_ptr_bad
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // payload bytes of a length code, and of a payload size code
  function automatic logic [6:0] dlc_bytes(input logic [3:0] dlc);
    case (dlc)
      4'h9:    dlc_bytes = 7'h0C;
      4'hA:    dlc_bytes = 7'h10;
      4'hB:    dlc_bytes = 7'h14;
      4'hC:    dlc_bytes = 7'h18;
      4'hD:    dlc_bytes = 7'h20;
      4'hE:    dlc_bytes = 7'h30;
      4'hF:    dlc_bytes = 7'h40;
      default: dlc_bytes = (dlc > 4'h8) ? 7'h08 : {3'h0, dlc};
    endcase
  endfunction

  function automatic logic [6:0] pl_bytes(input logic [2:0] pl);
    case (pl)
      3'h0:    pl_bytes = 7'h08;
      3'h1:    pl_bytes = 7'h0C;
      3'h2:    pl_bytes = 7'h10;
      3'h3:    pl_bytes = 7'h14;
      3'h4:    pl_bytes = 7'h18;
      3'h5:    pl_bytes = 7'h20;
      3'h6:    pl_bytes = 7'h30;
      default: pl_bytes = 7'h40;
    endcase
  endfunction

  // saturating increment so a counter never wraps back to zero
  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == 8'hFF) ? v : v + 8'h01;
  endfunction

  function automatic logic ptr_ok(input logic [4:0] p);
    ptr_ok = (p >= `CBDIAG_PTR_MIN) && (p <= `CBDIAG_PTR_MAX);
  endfunction

  // word index decode shared by the filter write strobe and the read port
  function automatic logic is_flt_addr(input logic [3:0] a);
    is_flt_addr = (a >= `CBDIAG_FLT_BASE_ADDR)
                  && (a <= `CBDIAG_FLT_LAST_ADDR);
  endfunction

  // ----------------------------------------------------------------
  // bus sample synchroniser
  // ----------------------------------------------------------------
  // both flops reset recessive, so no false dominant bit after reset
  logic bus_meta_q;
  logic bus_sync_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_meta_q <= 1'b1;
      bus_sync_q <= 1'b1;
    end else begin
      bus_meta_q <= bus_rx_pin;
      bus_sync_q <= bus_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  logic wr_data_cnt;
  logic wr_nom_cnt;
  logic wr_flags;
  logic wr_efmsg;
  logic wr_flt;
  logic [1:0] flt_widx;

  assign wr_data_cnt = reg_wr && (reg_addr == `CBDIAG_DATA_CNT_ADDR);
  assign wr_nom_cnt  = reg_wr && (reg_addr == `CBDIAG_NOM_CNT_ADDR);
  assign wr_flags    = reg_wr && (reg_addr == `CBDIAG_FLAGS_ADDR);
  assign wr_efmsg    = reg_wr && (reg_addr == `CBDIAG_EFMSG_ADDR);
  assign wr_flt      = reg_wr && is_flt_addr(reg_addr);
  assign flt_widx    = reg_addr[1:0];

  // ----------------------------------------------------------------
  // error counters
  // ----------------------------------------------------------------
  // a hardware increment in the cycle of a write wins: no event lost
  logic [7:0] data_tx_error_count_q;
  logic [7:0] data_rx_error_count_q;
  logic [7:0] nominal_tx_error_count_q;
  logic [7:0] nominal_rx_error_count_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_tx_error_count_q <= 8'h00;
    end else if (data_phase && tx_err_inc) begin
      data_tx_error_count_q <= sat_inc(data_tx_error_count_q);
    end else if (wr_data_cnt) begin
      data_tx_error_count_q <=
        reg_wdata[`CBDIAG_TX_CNT_MSB:`CBDIAG_TX_CNT_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_rx_error_count_q <= 8'h00;
    end else if (data_phase && rx_err_inc) begin
      data_rx_error_count_q <= sat_inc(data_rx_error_count_q);
    end else if (wr_data_cnt) begin
      data_rx_error_count_q <=
        reg_wdata[`CBDIAG_RX_CNT_MSB:`CBDIAG_RX_CNT_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nominal_tx_error_count_q <= 8'h00;
    end else if (!data_phase && tx_err_inc) begin
      nominal_tx_error_count_q <=
        sat_inc(nominal_tx_error_count_q);
    end else if (wr_nom_cnt) begin
      nominal_tx_error_count_q <=
        reg_wdata[`CBDIAG_TX_CNT_MSB:`CBDIAG_TX_CNT_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nominal_rx_error_count_q <= 8'h00;
    end else if (!data_phase && rx_err_inc) begin
      nominal_rx_error_count_q <=
        sat_inc(nominal_rx_error_count_q);
    end else if (wr_nom_cnt) begin
      nominal_rx_error_count_q <=
        reg_wdata[`CBDIAG_RX_CNT_MSB:`CBDIAG_RX_CNT_LSB];
    end
  end

  // ----------------------------------------------------------------
  // bus-off tracking and recessive run counter
  // ----------------------------------------------------------------
  cbdiag_state_t boff_state_q;
  logic [3:0]    rec_run_q;
  logic          rec_run_done;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      boff_state_q <= CBDIAG_RUN;
    end else begin
      case (boff_state_q)
        CBDIAG_RUN:  if (bus_off_enter) boff_state_q <= CBDIAG_BOFF;
        CBDIAG_BOFF: if (bus_off_exit) boff_state_q <= CBDIAG_RUN;
        default:     boff_state_q <= CBDIAG_RUN;
      endcase
    end
  end

  // the run restarts on any dominant bit, so a stuck bus never flags
  assign rec_run_done = (boff_state_q == CBDIAG_BOFF) && bit_tick
                        && bus_sync_q
                        && (rec_run_q == `CBDIAG_RECESSIVE_RUN - 4'h1);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rec_run_q <= 4'h0;
    end else if (boff_state_q != CBDIAG_BOFF) begin
      rec_run_q <= 4'h0;
    end else if (bit_tick) begin
      if (!bus_sync_q || rec_run_done)
        rec_run_q <= 4'h0;
      else
        rec_run_q <= rec_run_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // sticky flags
  // ----------------------------------------------------------------
  logic [15:0] flag_set;
  logic [15:0] flags_q;
  logic        dlc_over;

  assign dlc_over = dlc_check
    && (dlc_bytes(frame_dlc) > pl_bytes(fifo_payload_size));

  always_comb begin
    flag_set = 16'h0000;
    flag_set[`CBDIAG_F_LENGTH_MISMATCH_FLAG] = dlc_over;
    flag_set[`CBDIAG_F_ESI]   = rx_esi_seen;
    flag_set[`CBDIAG_F_DCRC]  = data_phase && crc_err;
    flag_set[`CBDIAG_F_DSTUF] = data_phase && stuff_err;
    flag_set[`CBDIAG_F_DFORM] = data_phase && form_err;
    flag_set[`CBDIAG_F_DBIT1] = data_phase && bit1_err;
    flag_set[`CBDIAG_F_DBIT0] = data_phase && bit0_err;
    flag_set[`CBDIAG_F_BOFF]  = (boff_state_q == CBDIAG_BOFF)
                                && bus_off_exit;
    flag_set[`CBDIAG_F_NCRC]  = !data_phase && crc_err;
    flag_set[`CBDIAG_F_NSTUF] = !data_phase && stuff_err;
    flag_set[`CBDIAG_F_NFORM] = !data_phase && form_err;
    flag_set[`CBDIAG_F_NACK]  = ack_err;
    flag_set[`CBDIAG_F_NBIT1] = !data_phase && bit1_err;
    flag_set[`CBDIAG_F_NBIT0] = (!data_phase && bit0_err)
                                || rec_run_done;
  end

  // set wins over a software clear in the same cycle
  // writing one keeps a flag, so clearing one bit spares the rest
  always_ff @(posedge clk) begin
    if (!rst_n)
      flags_q <= `CBDIAG_RESET_VAL;
    else if (wr_flags)
      flags_q <= ((flags_q & reg_wdata) | flag_set)
                 & `CBDIAG_FLAG_MASK;
    else
      flags_q <= (flags_q | flag_set) & `CBDIAG_FLAG_MASK;
  end

  // ----------------------------------------------------------------
  // error-free message counter
  // ----------------------------------------------------------------
  // wraps after all ones; software may rewrite it, but a frame_ok in the same cycle wins over the write
  logic [15:0] error_free_message_count_q;

  always_ff @(posedge clk) begin
    if (!rst_n)
      error_free_message_count_q <= 16'h0000;
    else if (frame_ok)
      error_free_message_count_q <=
        error_free_message_count_q + 16'h0001;
    else if (wr_efmsg)
      error_free_message_count_q <= reg_wdata;
  end

  // ----------------------------------------------------------------
  // upper filter routing words
  // ----------------------------------------------------------------
  logic [15:0] flt_ctl_q [NUM_FLT_WORDS];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_FLT_WORDS; i++)
        flt_ctl_q[i] <= `CBDIAG_RESET_VAL;
    end else if (wr_flt) begin
      flt_ctl_q[flt_widx] <= reg_wdata & `CBDIAG_FLT_MASK;
    end
  end

  // hit index: bits 3:2 pick the word, bit 0 picks byte c or d;
  // hits on filters a and b belong to the lower word, not here
  logic [15:0] hit_word;
  logic [7:0]  hit_byte;
  logic        hit_upper;
  logic        hit_en;
  logic [4:0]  hit_ptr;

  assign hit_word  = flt_ctl_q[flt_hit_index[3:2]];
  assign hit_byte  = flt_hit_index[0] ? hit_word[15:8] : hit_word[7:0];
  assign hit_upper = flt_hit && flt_hit_index[1];
  assign hit_en    = hit_byte[`CBDIAG_FLT_EN_BIT];
  assign hit_ptr   = hit_byte[`CBDIAG_FLT_PTR_MSB:0];

  // a reserved pointer never routes into an object
  always_ff @(posedge clk) begin
    if (!rst_n)
      store_valid <= 1'b0;
    else
      store_valid <= hit_upper && hit_en
                     && ptr_ok(hit_ptr);
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      store_object <= 5'h00;
    else
      store_object <= hit_ptr;
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      flt_ptr_bad <= 1'b0;
    else
      flt_ptr_bad <= hit_upper && hit_en
                     && !ptr_ok(hit_ptr);
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `CBDIAG_DATA_CNT_ADDR:
          reg_rdata <= {data_tx_error_count_q, data_rx_error_count_q};
        `CBDIAG_NOM_CNT_ADDR:
          reg_rdata <= {nominal_tx_error_count_q,
                        nominal_rx_error_count_q};
        `CBDIAG_FLAGS_ADDR: reg_rdata <= flags_q;
        `CBDIAG_EFMSG_ADDR: reg_rdata <= error_free_message_count_q;
        default:
          reg_rdata <= is_flt_addr(reg_addr) ? flt_ctl_q[reg_addr[1:0]]
                                             : 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

// File: bench/cbdiag_monitor.sv
/*
  checker for the diagnostics core, bound to its top ports.
  assumes one clock and a synchronous active-low reset.
*/
`default_nettype none
module cbdiag_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        flt_hit,
  input wire logic [3:0]  flt_hit_index,
  input wire logic        store_valid,
  input wire logic [4:0]  store_object,
  input wire logic        flt_ptr_bad
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  flag_gaps_a : assert property (
    reg_rd && reg_addr == 4'h2 |=> reg_rdata[10] == 1'b0
      && reg_rdata[6] == 1'b0) else $error("flag gap bit set");
  filter_gaps_a : assert property (
    reg_rd && reg_addr[3:2] == 2'b01 |=> (reg_rdata & 16'h6060) == 16'h0000)
    else $error("filter gap bit set");
  unmapped_zero_a : assert property (
    reg_rd && reg_addr[3] |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  read_pulse_a : assert property (
    !reg_rd |=> reg_rdata == 16'h0000) else $error("read data lingers");
  store_cause_a : assert property (
    store_valid |-> $past(flt_hit)) else $error("store without hit");
  store_range_a : assert property (
    store_valid |-> store_object inside {[5'h01:5'h07]})
    else $error("store object out of range");
  bad_cause_a : assert property (
    flt_ptr_bad |-> $past(flt_hit) && !store_valid)
    else $error("bad pointer pulse wrong");
  low_pair_a : assert property (
    flt_hit && !flt_hit_index[1] |=> !store_valid && !flt_ptr_bad)
    else $error("lower filter pair routed");
  reset_quiet_a : assert property (
    $rose(rst_n) |-> reg_rdata == 16'h0000 && !store_valid)
    else $error("outputs not quiet after reset");

  cover property (store_valid);
  cover property (flt_ptr_bad);
  cover property (reg_rd && reg_addr == 4'h2);
endmodule

bind cbdiag_core cbdiag_monitor u_mon (
  .clk           (clk),
  .rst_n         (rst_n),
  .reg_addr      (reg_addr),
  .reg_rd        (reg_rd),
  .reg_rdata     (reg_rdata),
  .flt_hit       (flt_hit),
  .flt_hit_index (flt_hit_index),
  .store_valid   (store_valid),
  .store_object  (store_object),
  .flt_ptr_bad   (flt_ptr_bad)
);
`default_nettype wire

// File: bench/cbdiag_bus_model.sv
/*
  far side of the bus pin: sends bit levels with one tick per bit.
  assumes the core samples the pin through two flops.
*/
`default_nettype none
module cbdiag_bus_model (
  input  wire logic clk,
  output logic      bit_tick,
  output logic      bus_rx_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    bit_tick = 1'b0;
    bus_rx_pin = 1'b1;
  end
  // tick waits out the synchroniser so the bit is seen settled
  task automatic send(input int n, input logic lvl);
    repeat (n) begin
      @(posedge clk);
      bus_rx_pin <= lvl;
      repeat (3) @(posedge clk);
      bit_tick <= 1'b1;
      @(posedge clk);
      bit_tick <= 1'b0;
      bus_rx_pin <= 1'b1;  // released bus idles recessive
    end
  endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
/*
  testbench of the diagnostics core: register tasks and event pulses.
  assumes the core, its package and the bus model are compiled first.
*/
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  miscompares++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        data_phase = 1'b0;
  logic [13:0] ev = 14'h0000;
  logic [3:0]  frame_dlc = 4'h0;
  logic [2:0]  psize = 3'h0;
  logic [3:0]  hit_idx = 4'h0;
  logic [15:0] reg_rdata;
  logic        bit_tick;
  logic        bus_rx_pin;
  logic        store_valid;
  logic        flt_ptr_bad;
  logic [4:0]  store_object;
  int          miscompares = 0;
  int          check_count = 0;
  int          evi[12] = '{3, 4, 5, 6, 7, 8, 3, 4, 5, 7, 8, 2};
  int          fbit[12] = '{5, 4, 3, 2, 1, 0, 13, 12, 11, 9, 8, 14};

  always #25 clk = ~clk;

  cbdiag_bus_model u_bus (.clk(clk), .bit_tick(bit_tick),
    .bus_rx_pin(bus_rx_pin));
  cbdiag_core u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .data_phase(data_phase), .tx_err_inc(ev[0]),
    .rx_err_inc(ev[1]), .dlc_check(ev[10]), .frame_dlc(frame_dlc),
    .fifo_payload_size(psize), .rx_esi_seen(ev[2]), .crc_err(ev[3]),
    .stuff_err(ev[4]), .form_err(ev[5]), .ack_err(ev[6]),
    .bit1_err(ev[7]), .bit0_err(ev[8]), .bus_off_enter(ev[11]),
    .bus_off_exit(ev[12]), .bit_tick(bit_tick), .bus_rx_pin(bus_rx_pin),
    .frame_ok(ev[9]), .flt_hit(ev[13]), .flt_hit_index(hit_idx),
    .store_valid(store_valid), .store_object(store_object),
    .flt_ptr_bad(flt_ptr_bad));

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  task automatic fire(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask
  task automatic hit(input logic [3:0] i, input logic v,
                     input logic [4:0] o, input logic b);
    @(posedge clk);
    ev[13] <= 1'b1;
    hit_idx <= i;
    @(posedge clk);
    ev[13] <= 1'b0;
    #1 `CHK(store_valid, v)
    `CHK(flt_ptr_bad, b)
    if (v) `CHK(store_object, o)
  endtask
  task automatic chk_flag(input int i);
    @(posedge clk);
    data_phase <= (i >= 6);
    fire(evi[i]);
    rd(4'h2, 16'h0001 << fbit[i]);
    wr(4'h2, 16'h0000);
    rd(4'h2, 16'h0000);
  endtask
  task automatic dlc(input logic [2:0] s, input logic [3:0] d,
                     input logic [15:0] e);
    @(posedge clk);
    psize <= s;
    frame_dlc <= d;
    fire(10);
    rd(4'h2, e);
    wr(4'h2, 16'h0000);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) rd(a[3:0], 16'h0000);
    wr(4'h9, 16'hFFFF);
    rd(4'h9, 16'h0000);
    $display("reset test done");
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      data_phase <= p[0];
      fire(0);
      fire(0);
      fire(1);
      rd(4'h0, p[0] ? 16'h0201 : 16'h0000);
      rd(4'h1, 16'h0201);
    end
    wr(4'h0, 16'hFE10);
    fire(0);
    fire(0);
    rd(4'h0, 16'hFF10);
    $display("counter test done");
    for (int i = 0; i < 6; i++) begin
      chk_flag(i);
    end
    for (int i = 6; i < 12; i++) chk_flag(i);
    wr(4'h2, 16'hFFFF);
    rd(4'h2, 16'h0000);
    dlc(3'h0, 4'h8, 16'h0000);
    dlc(3'h0, 4'h9, 16'h8000);
    dlc(3'h3, 4'hB, 16'h0000);
    dlc(3'h3, 4'hC, 16'h8000);
    $display("flag test done");
    wr(4'h3, 16'h00FF);
    fire(9);
    rd(4'h3, 16'h0100);
    $display("message count test done");
    fire(11);
    u_bus.send(10, 1'b1);
    rd(4'h2, 16'h0000);
    u_bus.send(1, 1'b1);
    rd(4'h2, 16'h0001);
    wr(4'h2, 16'h0000);
    u_bus.send(5, 1'b1);
    u_bus.send(1, 1'b0);
    u_bus.send(10, 1'b1);
    rd(4'h2, 16'h0000);
    u_bus.send(1, 1'b1);
    fire(12);
    rd(4'h2, 16'h0081);
    $display("recovery test done");
    wr(4'h5, 16'hFFFF);
    rd(4'h5, 16'h9F9F);
    wr(4'h4, 16'h0583);
    hit(4'h2, 1'b1, 5'h03, 1'b0);
    hit(4'h3, 1'b0, 5'h00, 1'b0);
    hit(4'h0, 1'b0, 5'h00, 1'b0);
    wr(4'h5, 16'h9881);
    hit(4'h6, 1'b1, 5'h01, 1'b0);
    hit(4'h7, 1'b0, 5'h00, 1'b1);
    wr(4'h6, 16'h8000);
    hit(4'hB, 1'b0, 5'h00, 1'b1);
    wr(4'h7, 16'h0087);
    hit(4'hE, 1'b1, 5'h07, 1'b0);
    hit(4'hF, 1'b0, 5'h00, 1'b0);
    $display("filter test done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) rd(a[3:0], 16'h0000);
    hit(4'hE, 1'b0, 5'h00, 1'b0);
    $display("mid reset test done");
    report_and_stop();
  end

  // tests need under 2000 cycles; five times that means a hang
  initial begin
    #500000;
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
